//--- lcfc_core.v
// Decoder and executor for AND, call, carry clear, divider clear and event clear
`timescale 1ns/10ps
`include "lcfc_regs.vh"
module lcfc_core #(
   parameter SDEPTH = 8
) (
   input  wire        CLOCK,
   input  wire        RESETN,
   input  wire        INSTR_VALID,
   input  wire [15:0] INSTR,
   input  wire        DIV0_TICK,
   input  wire        DIV0_OVF_IN,
   input  wire        TMR0_UNF_IN,
   input  wire        PORT_CHG_IN,
   input  wire        DIV1_OVF_IN,
   input  wire        TMR1_UNF_IN,
   output reg  [3:0]  ACC,
   output reg         ZERO_FLAG,
   output reg         CARRY_FLAG,
   output reg  [10:0] PC,
   output reg  [10:0] STACK_TOP,
   output reg  [3:0]  STACK_DEPTH,
   output reg  [13:0] DIV0_COUNT,
   output reg         DIVIDER0_OVERFLOW_EVENT,
   output reg         TIMER0_UNDERFLOW_EVENT,
   output reg         PORT_CHANGE_EVENT,
   output reg         DIVIDER1_OVERFLOW_EVENT,
   output reg         TIMER1_UNDERFLOW_EVENT,
   output reg         BUSY
);
   // ----------------------------------------
   // Decode
   // ----------------------------------------
   localparam ST_FETCH = 1'b0;
   localparam ST_EXEC  = 1'b1;

   reg         state_r;
   reg [15:0]  ir_r;
   reg [3:0]   wr_r [0:15];
   reg [10:0]  stack_r [0:SDEPTH-1];
   reg [3:0]   sp_r;
   integer     i;

   // Memory AND decodes serve both the fetched word and the held word
   function is_and_mem;
      input [15:0] w;
      begin
         is_and_mem = (w[15:7] == `OPC_AND_MEM);
      end
   endfunction

   function is_and_mem_wb;
      input [15:0] w;
      begin
         is_and_mem_wb = (w[15:7] == `OPC_AND_MEM_WB);
      end
   endfunction

   // Flag clears only with its mask bit set and no set arriving
   function clear_hit;
      input m;
      input s;
      begin
         clear_hit = m && !s;
      end
   endfunction

   wire op_and_mem    = is_and_mem(INSTR);
   wire op_and_mem_wb = is_and_mem_wb(INSTR);
   wire op_and_imm    = (INSTR[15:9] == `OPC_AND_IMM);
   wire op_and_imm_wb = (INSTR[15:8] == `OPC_AND_IMM_WB);
   wire x_mem         = is_and_mem(ir_r);
   wire x_mem_wb      = is_and_mem_wb(ir_r);

   wire [3:0] mem_rdata;
   wire [3:0] mem_and   = mem_rdata & ACC;
   wire [3:0] imm       = INSTR[`IMM_MSB:`IMM_LSB];
   wire [3:0] wr_idx    = INSTR[`WR_MSB:0];
   wire [3:0] wr_sel    = wr_r[wr_idx];
   wire [3:0] imm_and   = wr_sel & imm;
   wire [7:0] mask      = INSTR[7:0];

   function zero_of;
      input [3:0] v;
      begin
         zero_of = (v == 4'h0);
      end
   endfunction

   // Memory reads take one cycle, so memory ANDs finish in an execute beat
   lcfc_mem #(.AW(7), .DW(4)) u_mem (
      .clk   (CLOCK),
      .raddr (INSTR[`ADDR_MSB:0]),
      .rdata (mem_rdata),
      .we    ((state_r == ST_EXEC) && x_mem_wb),
      .waddr (ir_r[`ADDR_MSB:0]),
      .wdata (mem_and)
   );

   // ----------------------------------------
   // Execute
   // ----------------------------------------
   always @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         state_r                 <= ST_FETCH;
         ir_r                    <= 16'h0000;
         ACC                     <= `RST_ACC;
         ZERO_FLAG               <= 1'b0;
         CARRY_FLAG              <= 1'b0;
         PC                      <= `RST_PC;
         STACK_TOP               <= `RST_PC;
         STACK_DEPTH             <= 4'h0;
         sp_r                    <= 4'h0;
         DIV0_COUNT              <= `RST_DIV0;
         DIVIDER0_OVERFLOW_EVENT <= 1'b0;
         TIMER0_UNDERFLOW_EVENT  <= 1'b0;
         PORT_CHANGE_EVENT       <= 1'b0;
         DIVIDER1_OVERFLOW_EVENT <= 1'b0;
         TIMER1_UNDERFLOW_EVENT  <= 1'b0;
         BUSY                    <= 1'b0;
         for (i = 0; i < 16; i = i + 1) begin
            wr_r[i] <= 4'h0;
         end
         for (i = 0; i < SDEPTH; i = i + 1) begin
            stack_r[i] <= `RST_PC;
         end
      end else begin
         if (DIV0_TICK) begin
            DIV0_COUNT <= DIV0_COUNT + 14'h0001;
         end
         // Event flags: a set in the same cycle wins over the clear
         if (DIV0_OVF_IN) begin
            DIVIDER0_OVERFLOW_EVENT <= 1'b1;
         end
         if (TMR0_UNF_IN) begin
            TIMER0_UNDERFLOW_EVENT <= 1'b1;
         end
         if (PORT_CHG_IN) begin
            PORT_CHANGE_EVENT <= 1'b1;
         end
         if (DIV1_OVF_IN) begin
            DIVIDER1_OVERFLOW_EVENT <= 1'b1;
         end
         if (TMR1_UNF_IN) begin
            TIMER1_UNDERFLOW_EVENT <= 1'b1;
         end
         case (state_r)
            ST_FETCH: begin
               if (INSTR_VALID) begin
                  ir_r <= INSTR;
                  PC   <= PC + 11'h001;
                  if (op_and_mem || op_and_mem_wb) begin
                     state_r <= ST_EXEC;
                     BUSY    <= 1'b1;
                  end else if (op_and_imm) begin
                     ACC       <= imm_and;
                     ZERO_FLAG <= zero_of(imm_and);
                  end else if (op_and_imm_wb) begin
                     ACC                  <= imm_and;
                     wr_r[wr_idx]         <= imm_and;
                     ZERO_FLAG            <= zero_of(imm_and);
                  end else if (INSTR[15:11] == `OPC_CALL) begin
                     stack_r[sp_r[2:0]] <= PC + 11'h001;
                     STACK_TOP          <= PC + 11'h001;
                     PC                 <= INSTR[`CALL_MSB:0];
                     if (sp_r < SDEPTH) begin
                        sp_r        <= sp_r + 4'h1;
                        STACK_DEPTH <= sp_r + 4'h1;
                     end
                  end else if (INSTR == `OPC_CARRY_CLR) begin
                     CARRY_FLAG <= 1'b0;
                  end else if (INSTR == `OPC_DIV0_CLR) begin
                     DIV0_COUNT <= DIV0_COUNT & `DIV0_LOW_MASK;
                  end else if (INSTR[15:8] == `OPC_EVF_CLR) begin
                     // Mask bits 3, 5 and 6 are never looked at
                     if (clear_hit(mask[`MASK_DIV0_OVF], DIV0_OVF_IN)) begin
                        DIVIDER0_OVERFLOW_EVENT <= 1'b0;
                     end
                     if (clear_hit(mask[`MASK_TMR0_UNF], TMR0_UNF_IN)) begin
                        TIMER0_UNDERFLOW_EVENT <= 1'b0;
                     end
                     if (clear_hit(mask[`MASK_PORT_CHG], PORT_CHG_IN)) begin
                        PORT_CHANGE_EVENT <= 1'b0;
                     end
                     if (clear_hit(mask[`MASK_DIV1_OVF], DIV1_OVF_IN)) begin
                        DIVIDER1_OVERFLOW_EVENT <= 1'b0;
                     end
                     if (clear_hit(mask[`MASK_TMR1_UNF], TMR1_UNF_IN)) begin
                        TIMER1_UNDERFLOW_EVENT <= 1'b0;
                     end
                  end
               end
            end
            ST_EXEC: begin
               if (x_mem || x_mem_wb) begin
                  ACC       <= mem_and;
                  ZERO_FLAG <= zero_of(mem_and);
               end
               state_r <= ST_FETCH;
               BUSY    <= 1'b0;
            end
            default: begin
               state_r <= ST_FETCH;
               BUSY    <= 1'b0;
            end
         endcase
      end
   end
endmodule

//--- lcfc_core_properties.sv
// Port checks for the decoder core
`timescale 1ns/10ps
`include "lcfc_regs.vh"
module lcfc_core_checker (
   input wire logic        CLOCK,
   input wire logic        RESETN,
   input wire logic        INSTR_VALID,
   input wire logic [15:0] INSTR,
   input wire logic        DIV0_TICK,
   input wire logic        TMR1_UNF_IN,
   input wire logic [3:0]  ACC,
   input wire logic        ZERO_FLAG,
   input wire logic        CARRY_FLAG,
   input wire logic [10:0] PC,
   input wire logic [10:0] STACK_TOP,
   input wire logic [13:0] DIV0_COUNT,
   input wire logic        DIVIDER0_OVERFLOW_EVENT,
   input wire logic        DIV0_OVF_IN,
   input wire logic        TIMER1_UNDERFLOW_EVENT,
   input wire logic        BUSY
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RESETN);
   wire tk = INSTR_VALID && !BUSY;
   wire cl = tk && INSTR[15:11] == `OPC_CALL;
   wire ev = tk && INSTR[15:8] == `OPC_EVF_CLR;
   wire [10:0] call_tgt = INSTR[10:0];
   wire        mask7_bit = INSTR[7];
   sequence exec_beat;
      BUSY ##1 (!BUSY && ZERO_FLAG == (ACC == 4'h0));
   endsequence
   a_call_loads_pc: assert property (cl |=> PC == $past(call_tgt))
      else $error("call target wrong");
   a_call_pushes_ret: assert property (cl |=> STACK_TOP == $past(PC) + 11'h001)
      else $error("return address wrong");
   a_carry_clear: assert property (tk && INSTR == `OPC_CARRY_CLR |=> !CARRY_FLAG)
      else $error("carry not cleared");
   a_div_low_clear: assert property (tk && INSTR == `OPC_DIV0_CLR && !DIV0_TICK
      |=> DIV0_COUNT == ($past(DIV0_COUNT) & `DIV0_LOW_MASK)) else $error("divider clear wrong");
   a_divider0_overflow_event_cleared: assert property (ev && INSTR[0] && !DIV0_OVF_IN
      |=> !DIVIDER0_OVERFLOW_EVENT) else $error("divider event kept");
   a_timer1_underflow_event_masked: assert property (ev |=> TIMER1_UNDERFLOW_EVENT ==
      ($past(TMR1_UNF_IN) || $past(TIMER1_UNDERFLOW_EVENT) && !$past(mask7_bit)))
      else $error("timer event mask wrong");
   a_mem_and_beat: assert property (tk && INSTR[15:7] == `OPC_AND_MEM |=> exec_beat)
      else $error("memory and beat wrong");
   a_mem_wb_beat: assert property (tk && INSTR[15:7] == `OPC_AND_MEM_WB |=> exec_beat)
      else $error("write-back and beat wrong");
   a_imm_zero_flag: assert property (tk && INSTR[15:9] == `OPC_AND_IMM
      |=> ZERO_FLAG == (ACC == 4'h0)) else $error("zero flag wrong");
   a_and_keeps_carry: assert property (tk && INSTR[15:12] == 4'h2 |=> $stable(CARRY_FLAG))
      else $error("carry touched");
endmodule
bind lcfc_core lcfc_core_checker chk (.*);

//--- lcfc_mem.v
// Data memory (128 x 4) with registered read data and one write port
`timescale 1ns/10ps
module lcfc_mem #(
   parameter AW = 7,
   parameter DW = 4
) (
   input  wire          clk,
   input  wire [AW-1:0] raddr,
   output reg  [DW-1:0] rdata,
   input  wire          we,
   input  wire [AW-1:0] waddr,
   input  wire [DW-1:0] wdata
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

//--- lcfc_regs.vh
// Opcode encodings, field positions and reset values for the logic/call/clear decoder
`ifndef LCFC_REGS_VH
`define LCFC_REGS_VH
// ----------------------------------------
// Opcode patterns
// ----------------------------------------
`define OPC_AND_MEM      9'h054
`define OPC_AND_MEM_WB   9'h056
`define OPC_AND_IMM      7'h16
`define OPC_AND_IMM_WB   8'h2F
`define OPC_CALL         5'h0C
`define OPC_CARRY_CLR    16'h5000
`define OPC_DIV0_CLR     16'h1700
`define OPC_EVF_CLR      8'h40
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ADDR_MSB         6
`define IMM_MSB          7
`define IMM_LSB          4
`define WR_MSB           3
`define CALL_MSB         10
`define MASK_DIV0_OVF    0
`define MASK_TMR0_UNF    1
`define MASK_PORT_CHG    2
`define MASK_DIV1_OVF    4
`define MASK_TMR1_UNF    7
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_ACC          4'h0
`define RST_PC           11'h000
`define RST_DIV0         14'h0000
`define RST_EVF          5'h00
`define DIV0_LOW_MASK    14'h3FF0
`endif

//--- prog_rom.sv
// Program memory model feeding instruction words
`timescale 1ns/10ps
module prog_rom (
   input  wire logic [10:0] addr,
   output wire logic [15:0] word
);
   logic [15:0] mem [0:2047];
   initial for (int i = 0; i < 2048; i++) mem[i] = 16'hFFFF;
   assign word = mem[addr];
endmodule

//--- tb_top.sv
// Directed bench for the decoder core
`timescale 1ns/10ps
module tb_top;
   logic        clock = 1'h0;
   logic        resetn = 1'h0;
   logic        valid = 1'h0;
   logic        tick = 1'h0;
   logic [4:0]  set_in = 5'h00;
   logic [15:0] word;
   logic [3:0]  acc, depth;
   logic        zf, cf, busy;
   logic [10:0] pc, stop;
   logic [13:0] dcnt;
   logic [4:0]  evf;
   int          errors = 0;
   int          samples_checked = 0;
   always #4 clock = ~clock;
   prog_rom rom (.addr(pc), .word(word));
   lcfc_core uut (.CLOCK(clock), .RESETN(resetn), .INSTR_VALID(valid), .INSTR(word),
      .DIV0_TICK(tick), .DIV0_OVF_IN(set_in[0]), .TMR0_UNF_IN(set_in[1]),
      .PORT_CHG_IN(set_in[2]), .DIV1_OVF_IN(set_in[3]), .TMR1_UNF_IN(set_in[4]),
      .ACC(acc), .ZERO_FLAG(zf), .CARRY_FLAG(cf), .PC(pc), .STACK_TOP(stop),
      .STACK_DEPTH(depth), .DIV0_COUNT(dcnt), .DIVIDER0_OVERFLOW_EVENT(evf[0]),
      .TIMER0_UNDERFLOW_EVENT(evf[1]), .PORT_CHANGE_EVENT(evf[2]),
      .DIVIDER1_OVERFLOW_EVENT(evf[3]), .TIMER1_UNDERFLOW_EVENT(evf[4]), .BUSY(busy));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("errors %0d checks %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Offer one word at the current counter, wait out the busy beat
   task automatic exec(input logic [15:0] w);
      int n;
      @(negedge clock);
      rom.mem[pc] = w;
      valid = 1'h1;
      @(negedge clock);
      valid = 1'h0;
      for (n = 0; busy !== 1'h0 && n < 4; n++) @(negedge clock);
      if (n == 4) begin
         errors++;
         report_and_stop();
      end
   endtask
   initial begin
      int          pos [5] = '{0, 1, 2, 4, 7};
      repeat (12) @(negedge clock);
      resetn = 1'h1;
      check({acc, zf, cf, depth, evf}, 16'h0000);
      // Seed operands: the block has no load path of its own
      uut.wr_r[3] = 4'hA;
      uut.u_mem.mem[5] = 4'h6;
      uut.u_mem.mem[6] = 4'h9;
      exec(16'h2CF3);
      check({acc, zf, cf}, 16'h0028);
      check(uut.wr_r[3], 16'h000A);
      exec(16'h2A05);
      check({acc, zf, cf}, 16'h0008);
      check(uut.u_mem.mem[5], 16'h0006);
      exec(16'h2B06);
      check({acc, zf, cf}, 16'h0002);
      check(uut.u_mem.mem[6], 16'h0000);
      exec(16'h2F33);
      check({acc, zf, cf}, 16'h0008);
      exec(16'h2CF3);
      check({acc, zf, cf}, 16'h0008);
      exec(16'h67FF);
      check({stop, depth}, {11'h006, 4'h1});
      check(pc, 16'h07FF);
      exec(16'h6000);
      check({pc, depth}, 16'h0002);
      check(stop, 16'h0000);
      exec(16'h5000);
      check({acc, zf, cf}, 16'h0008);
      @(negedge clock);
      tick = 1'h1;
      repeat (37) @(negedge clock);
      tick = 1'h0;
      exec(16'h1700);
      check(dcnt, 16'h0020);
      @(negedge clock);
      set_in = 5'h1F;
      @(negedge clock);
      set_in = 5'h00;
      exec(16'h4068);
      check(evf, 16'h001F);
      for (int k = 0; k < 5; k++) begin
         exec(16'h4000 | (16'h0001 << pos[k]));
         check(evf, 16'h001F & (16'h001F << (k + 1)));
      end
      // Set and clear on one edge: the set must win
      set_in = 5'h10;
      exec(16'h4080);
      set_in = 5'h00;
      check(evf, 16'h0010);
      exec(16'h4080);
      check(evf, 16'h0000);
      report_and_stop();
   end
endmodule
